// File: design/vcp_capture_ctrl.sv
// video capture port control and status
`timescale 1ns/100ps
//Behaviour
//- separate end-of-VBI (bit 9) and end-of-video (bit 8) enables, reset off
//- end-of-VBI sets bit 1, end-of-video sets bit 0; software may write both
//- bit 6 shows incoming field, bit 2 field of last flip; 0 top
//- bit 5 shows live vertical state, 1 during active video
//- bits 4:3 show frame buffer being written, bit 10 VBI buffer
//- bit 7 flags a packed word lost because the capture fifo was full
//- bit 22 serial stream, bit 21 MSB first, bit 20 ignores packet start
//- switch buffer after count+1 packets, or after count kilobytes
//- move method: 0x notify driver, 10 notify DMA, 11 direct DMA
//- with error input and drop bit, errored packet data is discarded
//- separate polarity inverts for field out/in, horizontal, vertical, clock
//- bits 29 and 28 choose starting edge of vertical and horizontal refs
//- data written out once fifo holds more than threshold times unit
//- bit 23 swaps which capture clock pin clocks the engine
//- horizontal filter: none or 2 to 5 tap average, others reserved
//- de-interlace: odd only, even only, both same place, both interleaved
//- interleaved mode flips per frame when bit 15 clear, per field when set
//- bit 14 selects chroma duplication or interpolation
//- bit 11 enables field input, or error input in stream mode
//- bit 10 chooses task bit or blanking-time codes for VBI region
module vcp_capture_ctrl import vcp_pkg::*; #(
	parameter bit SECOND_ENGINE = 1'b0,
	parameter int FIFO_DEPTH = 64,
	parameter int THR_UNIT = 4
) (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	output logic REG_RVALID,
	input wire logic CAP_CLK0,
	input wire logic CAP_CLK1,
	input wire logic VREF_IN,
	input wire logic HORIZONTAL_REFERENCE_INPUT_IN,
	input wire logic FIELD_IN,
	input wire logic TASK_IN,
	input wire logic PKT_START_IN,
	input wire logic [7:0] DATA_IN,
	input wire logic OUT_READY,
	output logic OUT_VALID,
	output vcp_beat_t OUT_BEAT,
	output logic FIELD_OUT,
	output logic FLIP_OUT,
	output logic DRV_NOTIFY,
	output logic DMA_NOTIFY,
	output logic CHROMA_INTERP
);
	localparam int AW = $clog2(FIFO_DEPTH);
	if (FIFO_DEPTH != (1 << AW) || THR_UNIT * 15 >= FIFO_DEPTH) begin : g_bad_cfg
		$error("fifo depth must be a power of two above the largest threshold");
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// ----------------------------------------------------------------
	// pin synchronisation and polarity
	// ----------------------------------------------------------------
	logic [14:0] s;
	vcp_sync #(.W(15)) u_sync (
		.clk(SYS_CLK),
		.rst(RST),
		.d({TASK_IN, PKT_START_IN, FIELD_IN, HORIZONTAL_REFERENCE_INPUT_IN, VREF_IN, CAP_CLK1, CAP_CLK0, DATA_IN}),
		.q(s)
	);
	logic [31:0] irq_q, irq_d, ts_q, ts_d, if_q, if_d;
	logic cap_clk, vref_l, horizontal_reference_input_l, fld_l, ts_on, cap_en, tick;
	logic clk_prev_q, vref_prev_q, horizontal_reference_input_prev_q, vact_q, vact_d, hact_q, hact_d;
	logic v_start, v_end, h_start, h_end;
	always_comb begin
		cap_clk = (if_q[IF_CLK_SWAP] ^ SECOND_ENGINE) ? s[9] : s[8];
		cap_clk = cap_clk ^ if_q[IF_CLK_INV];
		vref_l = s[10] ^ if_q[IF_V_INV];
		horizontal_reference_input_l = s[11] ^ if_q[IF_H_INV];
		fld_l = s[12] ^ if_q[IF_FLD_INV];
		ts_on = ts_q[TS_EN];
		cap_en = if_q[IF_CAP_EN];
		tick = if_q[IF_CLK_EN] & cap_clk & ~clk_prev_q;
		v_start = if_q[IF_V_POS] ? (vref_l & ~vref_prev_q) : (~vref_l & vref_prev_q);
		v_end = if_q[IF_V_POS] ? (~vref_l & vref_prev_q) : (vref_l & ~vref_prev_q);
		h_start = if_q[IF_H_POS] ? (horizontal_reference_input_l & ~horizontal_reference_input_prev_q) : (~horizontal_reference_input_l & horizontal_reference_input_prev_q);
		h_end = if_q[IF_H_POS] ? (~horizontal_reference_input_l & horizontal_reference_input_prev_q) : (horizontal_reference_input_l & ~horizontal_reference_input_prev_q);
		vact_d = v_start | (vact_q & ~v_end);
		hact_d = h_start | (hact_q & ~h_end);
	end
	// ----------------------------------------------------------------
	// field, VBI and flip tracking
	// ----------------------------------------------------------------
	logic fld_cur_q, fld_cur_d, flip_fld_q, flip_fld_d, vbi_q, vbi_d, field_ok;
	logic eoav, vbi_end, flip, ts_err, vid_v;
	vcp_dei_t dei;
	always_comb begin
		dei = vcp_dei_t'(if_q[IF_DEI_HI:IF_DEI_LO]);
		// field pin doubles as error input
		fld_cur_d = if_q[IF_FLD_EN] & ~ts_on & fld_l;
		ts_err = if_q[IF_FLD_EN] & ts_on & fld_l;
		vbi_d = if_q[IF_VIP2] ? (~vact_q & hact_q) : s[14];
		vbi_end = cap_en & ~ts_on & vbi_q & ~vbi_d;
		eoav = cap_en & ~ts_on & vact_q & v_end;
		case (dei)
			DEI_ODD: field_ok = ~fld_cur_q;
			DEI_EVEN: field_ok = fld_cur_q;
			default: field_ok = 1'b1;
		endcase
		// interleaved flip per frame or field
		flip = eoav & field_ok & ((dei != DEI_INTERLEAVE) | if_q[IF_FLIP_FLD] | fld_cur_q);
		flip_fld_d = flip ? fld_cur_q : flip_fld_q;
		vid_v = tick & cap_en & ~ts_on & vact_q & hact_q & field_ok;
	end
	// ----------------------------------------------------------------
	// horizontal filter
	// ----------------------------------------------------------------
	logic [7:0] h1_q, h2_q, h3_q, h4_q, filt;
	logic [10:0] x0, x1, x2, x3, x4, acc;
	always_comb begin
		x0 = {3'h0, s[7:0]};
		x1 = {3'h0, h1_q};
		x2 = {3'h0, h2_q};
		x3 = {3'h0, h3_q};
		x4 = {3'h0, h4_q};
		// tap weights, reserved codes pass through
		case (vcp_filt_t'(if_q[IF_FILT_HI:IF_FILT_LO]))
			FLT_TAP2: acc = (x0 + x1) >> 1;
			FLT_TAP3: acc = (x0 + (x1 << 1) + x2) >> 2;
			FLT_TAP4: acc = (x0 + 11'h3 * x1 + 11'h3 * x2 + x3) >> 3;
			FLT_TAP5: acc = (x0 + ((x1 + x2 + x3) << 1) + x4) >> 3;
			default: acc = x0;
		endcase
		filt = acc[7:0];
	end
	// ----------------------------------------------------------------
	// transport stream bytes, packets and buffer switching
	// ----------------------------------------------------------------
	logic [7:0] sh_q, sh_d, pos_q, pos_d, cur_pos, ts_byte;
	logic [2:0] sbit_q, sbit_d;
	logic [14:0] pkt_q, pkt_d;
	logic [24:0] tsb_q, tsb_d;
	logic perr_q, perr_d, ts_tick, ts_byte_v, pkt_end, drop, ts_sw;
	vcp_move_t move;
	always_comb begin
		ts_tick = tick & cap_en & ts_on;
		move = vcp_move_t'(ts_q[TS_MOVE_HI:TS_MOVE_LO]);
		// serial bit order and byte framing
		sh_d = ts_q[TS_MSB_FIRST] ? {sh_q[6:0], s[0]} : {s[0], sh_q[7:1]};
		sbit_d = sbit_q;
		ts_byte_v = 1'b0;
		ts_byte = s[7:0];
		if (ts_tick && ts_q[TS_SERIAL]) begin
			sbit_d = sbit_q + 3'h1;
			ts_byte_v = (sbit_q == 3'h7);
			ts_byte = sh_d;
		end else if (ts_tick) begin
			ts_byte_v = 1'b1;
		end
		if (!(ts_tick && ts_q[TS_SERIAL])) begin
			sh_d = sh_q;
		end
		cur_pos = (~ts_q[TS_PST_DIS] & s[13]) ? 8'h0 : pos_q;
		pkt_end = ts_byte_v & (cur_pos == TS_PKT_LAST);
		pos_d = ts_byte_v ? (pkt_end ? 8'h0 : cur_pos + 8'h1) : pos_q;
		perr_d = ts_byte_v ? (((cur_pos == 8'h0) ? 1'b0 : perr_q) | ts_err) : perr_q;
		drop = ts_q[TS_DROP] & if_q[IF_FLD_EN] & (perr_q & (cur_pos != 8'h0) | ts_err);
		ts_sw = 1'b0;
		pkt_d = pkt_q;
		tsb_d = tsb_q;
		if (ts_q[TS_KB_MODE] && ts_byte_v) begin
			tsb_d = tsb_q + 25'h1;
			if (tsb_d == {ts_q[TS_CNT_HI:TS_CNT_LO], 10'h0}) begin
				ts_sw = 1'b1;
				tsb_d = '0;
			end
		end else if (pkt_end) begin
			pkt_d = pkt_q + 15'h1;
			if (pkt_q == ts_q[TS_CNT_HI:TS_CNT_LO]) begin
				ts_sw = 1'b1;
				pkt_d = '0;
			end
		end
	end
	// ----------------------------------------------------------------
	// word packing and capture fifo
	// ----------------------------------------------------------------
	logic [63:0] word_q, word_d;
	logic [2:0] bcnt_q, bcnt_d;
	logic [1:0] bidx_q, bidx_d;
	logic [AW:0] wp_q, wp_d, rp_q, rp_d, cnt;
	logic [7:0] byte_in;
	logic byte_v, push, full, rd, pend_q, drain_q, drain_d;
	logic [$bits(vcp_beat_t)-1:0] rdata;
	vcp_beat_t beat_q, beat_d, wbeat;
	logic ov_q, ov_d;
	always_comb begin
		byte_v = vid_v | (ts_byte_v & ~drop);
		byte_in = vid_v ? filt : ts_byte;
		word_d = byte_v ? {byte_in, word_q[63:8]} : word_q;
		bcnt_d = byte_v ? bcnt_q + 3'h1 : bcnt_q;
		cnt = wp_q - rp_q;
		full = (cnt == (AW + 1)'(FIFO_DEPTH));
		push = byte_v & (bcnt_q == 3'h7) & ~full;
		wbeat = '{to_dma: ts_on & (move == MV_DIRECT), bidx: bidx_q, data: word_d};
		wp_d = push ? wp_q + 1'b1 : wp_q;
		drain_d = drain_q ? (cnt != '0) : (cnt > (AW + 1)'(if_q[IF_THR_HI:IF_THR_LO] * THR_UNIT));
		rd = drain_q & (cnt != '0) & ~pend_q & ~ov_q;
		rp_d = rd ? rp_q + 1'b1 : rp_q;
		ov_d = pend_q | (ov_q & ~OUT_READY);
		beat_d = pend_q ? vcp_beat_t'(rdata) : beat_q;
		// buffer advance on flip or stream switch
		bidx_d = bidx_q;
		if ((flip & ~ts_on) | ts_sw) begin
			bidx_d = (bidx_q == NUM_BUFS - 2'h1) ? 2'h0 : bidx_q + 2'h1;
		end
	end
	vcp_mem #(.W($bits(vcp_beat_t)), .DEPTH(FIFO_DEPTH)) u_mem (
		.clk(SYS_CLK),
		.we(push),
		.waddr(wp_q[AW-1:0]),
		.wdata(wbeat),
		.re(rd),
		.raddr(rp_q[AW-1:0]),
		.rdata(rdata)
	);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [31:0] rdata_d, wmask;
	logic drv_d, dma_d, hit_irq;
	always_comb begin
		hit_irq = REG_WR & (REG_ADDR == VCP_IRQ_OFS);
		wmask = hit_irq ? VCP_IRQ_WMASK : 32'h0;
		irq_d = (irq_q & ~wmask) | (REG_WDATA & wmask);
		irq_d[IRQ_EOAV] = irq_d[IRQ_EOAV] | eoav;
		irq_d[IRQ_EOVBI] = irq_d[IRQ_EOVBI] | vbi_end;
		irq_d[IRQ_FULL] = irq_d[IRQ_FULL] | (byte_v & (bcnt_q == 3'h7) & full);
		// VBI buffer toggles per VBI end
		irq_d[IRQ_VBI_ID] = irq_d[IRQ_VBI_ID] ^ vbi_end;
		ts_d = ts_q;
		if_d = if_q;
		if (REG_WR && REG_ADDR == VCP_TS_OFS) begin
			ts_d = REG_WDATA & VCP_TS_WMASK;
		end else if (REG_WR && REG_ADDR == VCP_IF_OFS) begin
			if_d = REG_WDATA;
		end
		rdata_d = 32'h0;
		if (REG_ADDR == VCP_IRQ_OFS) begin
			rdata_d = irq_q & VCP_IRQ_WMASK;
			rdata_d[IRQ_CUR_FLD] = fld_cur_q;
			rdata_d[IRQ_VSYNC] = vact_q;
			rdata_d[IRQ_BUF_LO+1:IRQ_BUF_LO] = bidx_q;
			rdata_d[IRQ_FLIP_FLD] = flip_fld_q;
		end else if (REG_ADDR == VCP_TS_OFS) begin
			rdata_d = ts_q;
		end else if (REG_ADDR == VCP_IF_OFS) begin
			rdata_d = if_q;
		end
		drv_d = (eoav & irq_q[IRQ_AV_EN]) | (vbi_end & irq_q[IRQ_VBI_EN]);
		drv_d = drv_d | (ts_sw & ~move[1]);
		dma_d = ts_sw & (move == MV_FB_DMA);
	end
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			irq_q <= VCP_IRQ_RST;
			ts_q <= VCP_TS_RST;
			if_q <= VCP_IF_RST;
			{clk_prev_q, vref_prev_q, horizontal_reference_input_prev_q, vact_q, hact_q} <= '0;
			{fld_cur_q, flip_fld_q, vbi_q, perr_q, pend_q, drain_q, ov_q} <= '0;
			{h1_q, h2_q, h3_q, h4_q, sh_q, pos_q} <= '0;
			{sbit_q, pkt_q, tsb_q, word_q, bcnt_q, bidx_q, wp_q, rp_q} <= '0;
			beat_q <= '0;
			{REG_RDATA, REG_RVALID, OUT_VALID, OUT_BEAT} <= '0;
			{FIELD_OUT, FLIP_OUT, DRV_NOTIFY, DMA_NOTIFY, CHROMA_INTERP} <= '0;
		end else begin
			irq_q <= irq_d;
			ts_q <= ts_d;
			if_q <= if_d;
			clk_prev_q <= cap_clk;
			vref_prev_q <= vref_l;
			horizontal_reference_input_prev_q <= horizontal_reference_input_l;
			vact_q <= vact_d;
			hact_q <= hact_d;
			fld_cur_q <= fld_cur_d;
			flip_fld_q <= flip_fld_d;
			vbi_q <= vbi_d;
			if (vid_v) begin
				{h4_q, h3_q, h2_q, h1_q} <= {h3_q, h2_q, h1_q, s[7:0]};
			end
			sh_q <= sh_d;
			sbit_q <= sbit_d;
			pos_q <= pos_d;
			perr_q <= perr_d;
			pkt_q <= pkt_d;
			tsb_q <= tsb_d;
			word_q <= word_d;
			bcnt_q <= bcnt_d;
			bidx_q <= bidx_d;
			wp_q <= wp_d;
			rp_q <= rp_d;
			pend_q <= rd;
			drain_q <= drain_d;
			ov_q <= ov_d;
			beat_q <= beat_d;
			REG_RDATA <= rdata_d;
			REG_RVALID <= REG_RD;
			OUT_VALID <= ov_d;
			OUT_BEAT <= beat_d;
			FIELD_OUT <= fld_cur_q ^ if_q[IF_FLD_OUT_INV];
			FLIP_OUT <= flip;
			DRV_NOTIFY <= drv_d;
			DMA_NOTIFY <= dma_d;
			CHROMA_INTERP <= if_q[IF_CHR_INTERP];
		end
	end
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_fetch;
		rd ##1 pend_q ##1 OUT_VALID;
	endsequence
	a_vid_irq_gate: assert property (eoav && !irq_q[IRQ_AV_EN] && !vbi_end && !ts_sw
		|=> !DRV_NOTIFY) else $error("video end notified while disabled");
	a_vbi_flag_set: assert property (vbi_end |=> irq_q[IRQ_EOVBI] && irq_q[IRQ_VBI_ID]
		!= $past(irq_q[IRQ_VBI_ID])) else $error("VBI end not recorded");
	a_flip_field_cap: assert property (flip |=> flip_fld_q == $past(fld_cur_q))
		else $error("flipped field not captured");
	a_vsync_read_back: assert property (REG_RD && REG_ADDR == VCP_IRQ_OFS
		|=> REG_RVALID && REG_RDATA[IRQ_VSYNC] == $past(vact_q)) else $error("bad vsync");
	a_buf_advance: assert property (ts_sw |=> bidx_q != $past(bidx_q))
		else $error("buffer index did not move");
	a_fifo_full_flag: assert property (byte_v && bcnt_q == 3'h7 && full
		|=> irq_q[IRQ_FULL] && wp_q == $past(wp_q)) else $error("full not flagged");
	a_serial_framing: assert property (ts_tick && ts_q[TS_SERIAL] && sbit_q != 3'h7
		|-> !ts_byte_v) else $error("serial byte too early");
	a_dma_notify: assert property (ts_sw && move == MV_FB_DMA
		|=> DMA_NOTIFY && !$past(drv_d)) else $error("DMA notice missing");
	a_drop_error: assert property (ts_byte_v && drop |-> !byte_v)
		else $error("errored packet byte kept");
	a_drain_start: assert property (!drain_q && cnt > (AW + 1)'(if_q[IF_THR_HI:IF_THR_LO]
		* THR_UNIT) |=> drain_q) else $error("drain did not start");
	a_fetch_path: assert property (rd |-> s_fetch)
		else $error("fifo read not delivered in two cycles");
endmodule : vcp_capture_ctrl

// File: design/vcp_mem.sv
// capture fifo storage with registered read data
`timescale 1ns/100ps
module vcp_mem #(
	parameter int W = 64,
	parameter int DEPTH = 64
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic re,
	input wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [W-1:0] rdata
);
	logic [W-1:0] mem [DEPTH];
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		if (re) begin
			rdata <= mem[raddr];
		end
	end
endmodule : vcp_mem

// File: design/vcp_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module vcp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule : vcp_sync

// File: shared/vcp_pkg.sv
// shared constants and types of the video capture port control
package vcp_pkg;
	// ----------------------------------------------------------------
	// register offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] VCP_IRQ_OFS = 16'h0300;
	localparam logic [15:0] VCP_TS_OFS = 16'h0308;
	localparam logic [15:0] VCP_IF_OFS = 16'h0310;
	localparam logic [31:0] VCP_IRQ_RST = 32'h00000000;
	localparam logic [31:0] VCP_TS_RST = 32'h00000000;
	localparam logic [31:0] VCP_IF_RST = 32'h00000000;
	localparam logic [31:0] VCP_IRQ_WMASK = 32'h00000783;
	localparam logic [31:0] VCP_TS_WMASK = 32'h007FFFFF;
	// ----------------------------------------------------------------
	// interrupt control and flags fields
	// ----------------------------------------------------------------
	localparam int IRQ_VBI_ID = 10;
	localparam int IRQ_VBI_EN = 9;
	localparam int IRQ_AV_EN = 8;
	localparam int IRQ_FULL = 7;
	localparam int IRQ_CUR_FLD = 6;
	localparam int IRQ_VSYNC = 5;
	localparam int IRQ_BUF_LO = 3;
	localparam int IRQ_FLIP_FLD = 2;
	localparam int IRQ_EOVBI = 1;
	localparam int IRQ_EOAV = 0;
	// ----------------------------------------------------------------
	// transport stream control fields
	// ----------------------------------------------------------------
	localparam int TS_SERIAL = 22;
	localparam int TS_MSB_FIRST = 21;
	localparam int TS_PST_DIS = 20;
	localparam int TS_KB_MODE = 19;
	localparam int TS_CNT_HI = 18;
	localparam int TS_CNT_LO = 4;
	localparam int TS_MOVE_HI = 3;
	localparam int TS_MOVE_LO = 2;
	localparam int TS_DROP = 1;
	localparam int TS_EN = 0;
	// ----------------------------------------------------------------
	// capture interface control fields
	// ----------------------------------------------------------------
	localparam int IF_CLK_EN = 31;
	localparam int IF_FLD_OUT_INV = 30;
	localparam int IF_V_POS = 29;
	localparam int IF_H_POS = 28;
	localparam int IF_THR_HI = 27;
	localparam int IF_THR_LO = 24;
	localparam int IF_CLK_SWAP = 23;
	localparam int IF_FLD_INV = 22;
	localparam int IF_H_INV = 21;
	localparam int IF_V_INV = 20;
	localparam int IF_CLK_INV = 19;
	localparam int IF_FILT_HI = 18;
	localparam int IF_FILT_LO = 16;
	localparam int IF_FLIP_FLD = 15;
	localparam int IF_CHR_INTERP = 14;
	localparam int IF_DEI_HI = 13;
	localparam int IF_DEI_LO = 12;
	localparam int IF_FLD_EN = 11;
	localparam int IF_VIP2 = 10;
	localparam int IF_CAP_EN = 0;
	// ----------------------------------------------------------------
	// stream constants and types
	// ----------------------------------------------------------------
	localparam logic [7:0] TS_PKT_LAST = 8'hBB;
	localparam int KB_SHIFT = 10;
	localparam logic [1:0] NUM_BUFS = 2'h3;
	typedef enum logic [1:0] {MV_FB_DRV0, MV_FB_DRV1, MV_FB_DMA, MV_DIRECT} vcp_move_t;
	typedef enum logic [1:0] {DEI_ODD, DEI_EVEN, DEI_SAME, DEI_INTERLEAVE} vcp_dei_t;
	typedef enum logic [2:0] {FLT_NONE, FLT_TAP2, FLT_TAP3, FLT_TAP4, FLT_TAP5} vcp_filt_t;
	typedef struct packed {
		logic to_dma;
		logic [1:0] bidx;
		logic [63:0] data;
	} vcp_beat_t;
endpackage : vcp_pkg

// File: testbench/tb_top.sv
// self-checking bench of the video capture port control
`timescale 1ns/100ps
module tb_top import vcp_pkg::*;;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [31:0] reg_wdata = 32'h00000000;
	logic [31:0] reg_rdata;
	logic reg_rvalid;
	logic cap_clk, vref, horizontal_reference_input, field, task_bit, pkt_start;
	logic [7:0] data;
	logic out_ready = 1'b0;
	logic stall_all = 1'b0;
	logic clk_sel = 1'b0;
	int flip_seen = 0;
	int dma_seen = 0;
	logic out_valid, field_out, flip_out, drv_notify, dma_notify, chroma_interp;
	vcp_beat_t out_beat;
	vcp_beat_t beats[$];
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int drv_seen = 0;
	int drv0;

	vcp_capture_ctrl i_vcp_capture_ctrl (.SYS_CLK(sys_clk), .RST(rst), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.REG_RVALID(reg_rvalid), .CAP_CLK0(cap_clk & ~clk_sel),
		.CAP_CLK1(cap_clk & clk_sel), .VREF_IN(vref),
		.HORIZONTAL_REFERENCE_INPUT_IN(horizontal_reference_input), .FIELD_IN(field), .TASK_IN(task_bit), .PKT_START_IN(pkt_start),
		.DATA_IN(data), .OUT_READY(out_ready), .OUT_VALID(out_valid), .OUT_BEAT(out_beat),
		.FIELD_OUT(field_out), .FLIP_OUT(flip_out), .DRV_NOTIFY(drv_notify),
		.DMA_NOTIFY(dma_notify), .CHROMA_INTERP(chroma_interp));
	vcp_src_model i_vcp_src_model (.cap_clk(cap_clk), .vref(vref), .horizontal_reference_input(horizontal_reference_input),
		.field(field), .task_bit(task_bit), .pkt_start(pkt_start), .data(data));

	always #10 sys_clk = ~sys_clk;

	// ----------------------------------------------------------------
	// sink with stalls, beat collection, timeout
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		out_ready <= ~stall_all & cyc[2];
		if (out_valid === 1'b1 && out_ready === 1'b1)
			beats.push_back(out_beat);
		if (drv_notify === 1'b1)
			drv_seen <= drv_seen + 1;
		if (flip_out === 1'b1)
			flip_seen <= flip_seen + 1;
		if (dma_notify === 1'b1)
			dma_seen <= dma_seen + 1;
		if (cyc == 50000) begin
			err_total = err_total + 1;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("compares %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_beat(input vcp_beat_t got, input vcp_beat_t exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_beat

	task automatic reg_write(input logic [15:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : reg_write

	task automatic check_reg(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
		int n;
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		n = 0;
		#1;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		check_word((n < 4) ? (reg_rdata & m) : 32'hXXXXXXXX, e);
	endtask : check_reg

	function automatic vcp_beat_t mk_beat(input logic [7:0] base, input logic dma,
		input logic [1:0] bidx);
		vcp_beat_t r;
		r.to_dma = dma;
		r.bidx = bidx;
		for (int j = 0; j < 8; j++)
			r.data[8 * j +: 8] = base + 8'(j);
		return r;
	endfunction : mk_beat

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		check_reg(VCP_IRQ_OFS, 32'hFFFFFFFF, 32'h00000000);
		check_reg(VCP_TS_OFS, 32'hFFFFFFFF, 32'h00000000);
		check_reg(VCP_IF_OFS, 32'hFFFFFFFF, 32'h00000000);
		reg_write(VCP_IRQ_OFS, 32'hFFFFFFFF);
		check_reg(VCP_IRQ_OFS, 32'hFFFFFFFF, 32'h00000783);
		reg_write(VCP_IRQ_OFS, 32'h00000000);
		check_reg(VCP_IRQ_OFS, 32'hFFFFFFFF, 32'h00000000);
		reg_write(VCP_TS_OFS, 32'hFFFFFFFF);
		check_reg(VCP_TS_OFS, 32'hFFFFFFFF, 32'h007FFFFF);
		reg_write(VCP_TS_OFS, 32'h00000000);
		reg_write(16'h0304, 32'hFFFFFFFF);
		check_reg(16'h0304, 32'hFFFFFFFF, 32'h00000000);
		reg_write(VCP_IF_OFS, 32'hC0004000);
		check_reg(VCP_IF_OFS, 32'hFFFFFFFF, 32'hC0004000);
		repeat (4) @(posedge sys_clk);
		check_word({31'h0, chroma_interp}, 32'h1);
		check_word({31'h0, field_out}, 32'h1);
		$display("test registers done");
		reg_write(VCP_IF_OFS, 32'hA0000000);
		i_vcp_src_model.set_vref(1'b1, 4);
		check_reg(VCP_IRQ_OFS, 32'h00000020, 32'h00000020);
		i_vcp_src_model.set_vref(1'b0, 4);
		check_reg(VCP_IRQ_OFS, 32'h00000020, 32'h00000000);
		reg_write(VCP_IF_OFS, 32'h80000000);
		i_vcp_src_model.set_vref(1'b1, 4);
		i_vcp_src_model.set_vref(1'b0, 4);
		check_reg(VCP_IRQ_OFS, 32'h00000020, 32'h00000020);
		i_vcp_src_model.set_vref(1'b1, 4);
		check_reg(VCP_IRQ_OFS, 32'h00000020, 32'h00000000);
		$display("test vertical state done");
		reg_write(VCP_TS_OFS, 32'h00000011);
		reg_write(VCP_IF_OFS, 32'h80000000);
		reg_write(VCP_IF_OFS, 32'h80000001);
		beats.delete();
		drv0 = drv_seen;
		i_vcp_src_model.send_pkt(1'b0, 1'b0, 8'h10);
		repeat (40) @(posedge sys_clk);
		check_reg(VCP_IRQ_OFS, 32'h00000018, 32'h00000000);
		i_vcp_src_model.send_pkt(1'b0, 1'b0, 8'hCC);
		repeat (200) @(posedge sys_clk);
		check_reg(VCP_IRQ_OFS, 32'h00000018, 32'h00000008);
		check_word(32'(beats.size()), 32'd47);
		check_beat(beats[0], mk_beat(8'h10, 1'b0, 2'h0));
		check_word(32'(drv_seen - drv0), 32'd1);
		$display("test parallel stream done");
		stall_all = 1'b1;
		repeat (4) i_vcp_src_model.send_pkt(1'b0, 1'b0, 8'h00);
		check_reg(VCP_IRQ_OFS, 32'h00000080, 32'h00000080);
		stall_all = 1'b0;
		repeat (1500) @(posedge sys_clk);
		check_reg(VCP_IRQ_OFS, 32'h00000018, 32'h00000000);
		reg_write(VCP_IRQ_OFS, 32'h00000000);
		$display("test fifo full done");
		reg_write(VCP_TS_OFS, 32'h00000000);
		reg_write(VCP_IRQ_OFS, 32'h00000300);
		reg_write(VCP_IF_OFS, 32'hB0012801);
		beats.delete();
		drv0 = drv_seen;
		i_vcp_src_model.drive(4'b0000, 8'h00, 2);
		i_vcp_src_model.drive(4'b0001, 8'h00, 2);
		i_vcp_src_model.drive(4'b1000, 8'h00, 2);
		i_vcp_src_model.drive(4'b1100, 8'h20, 8);
		i_vcp_src_model.drive(4'b1010, 8'h00, 2);
		i_vcp_src_model.drive(4'b0010, 8'h00, 2);
		check_reg(VCP_IRQ_OFS, 32'h00000044, 32'h00000044);
		check_reg(VCP_IRQ_OFS, 32'h00000403, 32'h00000403);
		check_reg(VCP_IRQ_OFS, 32'h00000018, 32'h00000008);
		check_word(32'(drv_seen - drv0), 32'd2);
		check_word(32'(flip_seen), 32'd1);
		check_beat(beats[0], vcp_beat_t'{1'b0, 2'h0, 64'h2625242322212010});
		$display("test video capture done");
		reg_write(VCP_IF_OFS, 32'h80000800);
		reg_write(VCP_TS_OFS, 32'h0000000B);
		reg_write(VCP_IF_OFS, 32'h80000801);
		beats.delete();
		i_vcp_src_model.send_pkt(1'b0, 1'b0, 8'h50);
		repeat (40) @(posedge sys_clk);
		check_word(32'(beats.size()), 32'd0);
		check_word(32'(dma_seen), 32'd1);
		check_reg(VCP_IRQ_OFS, 32'h00000018, 32'h00000010);
		$display("test error drop done");
		clk_sel = 1'b1;
		reg_write(VCP_IF_OFS, 32'h81800001);
		reg_write(VCP_TS_OFS, 32'h0060001D);
		beats.delete();
		i_vcp_src_model.send_pkt(1'b1, 1'b1, 8'h30);
		repeat (100) @(posedge sys_clk);
		check_beat(beats[0], mk_beat(8'h30, 1'b1, 2'h2));
		$display("test serial stream done");
		print_verdict();
	end
endmodule : tb_top

// File: testbench/vcp_src_model.sv
// behavioural decoder and stream source driving the capture pins
`timescale 1ns/100ps
module vcp_src_model (
	output logic cap_clk,
	output logic vref,
	output logic horizontal_reference_input,
	output logic field,
	output logic task_bit,
	output logic pkt_start,
	output logic [7:0] data
);
	initial begin
		cap_clk = 1'b0;
		vref = 1'b0;
		horizontal_reference_input = 1'b0;
		field = 1'b0;
		task_bit = 1'b0;
		pkt_start = 1'b0;
		data = 8'h00;
	end
	// one capture clock period, clock stands low between frames
	task automatic tick;
		#80;
		cap_clk = 1'b1;
		#80;
		cap_clk = 1'b0;
	endtask : tick
	// pins move 5 ns after a system edge, never on it; each task returns aligned
	task automatic set_vref(input logic v, input int n);
		#5;
		vref = v;
		repeat (n) tick();
		#15;
	endtask : set_vref
	// video pins {vref, horizontal_reference_input, field, task} held for n clocks, data counting up
	task automatic drive(input logic [3:0] vhft, input logic [7:0] base, input int n);
		#5;
		for (int k = 0; k < n; k++) begin
			{vref, horizontal_reference_input, field, task_bit} = vhft;
			data = base + 8'(k);
			tick();
		end
		#15;
	endtask : drive
	task automatic send_pkt(input logic ser, input logic msb, input logic [7:0] base);
		logic [7:0] b;
		#5;
		for (int k = 0; k < 188; k++) begin
			b = base + 8'(k);
			pkt_start = (k == 0);
			if (!ser) begin
				data = b;
				tick();
			end else begin
				for (int i = 0; i < 8; i++) begin
					data[0] = msb ? b[7 - i] : b[i];
					tick();
				end
			end
		end
		pkt_start = 1'b0;
		// released bus shows the inverse of the last value
		data = ~data;
		#15;
	endtask : send_pkt
endmodule : vcp_src_model
